// ---- hdl/blldl_defs.svh ----
// Offsets, field positions and reset values of the battery-low register
`ifndef BLLDL_DEFS_SVH
`define BLLDL_DEFS_SVH
`define BLLDL_REG_OFFSET 8'h0B
`define BLLDL_LIMIT_LSB 0
`define BLLDL_LIMIT_MSB 7
`define BLLDL_DSCHG_EN_BIT 8
`define BLLDL_THR_LSB 9
`define BLLDL_THR_MSB 10
`define BLLDL_ACT_BIT 11
`define BLLDL_PRE_BIT 12
`define BLLDL_LOW_EN_BIT 13
`define BLLDL_LIMIT_RST 8'h80
`define BLLDL_DSCHG_EN_RST 1'h0
`define BLLDL_THR_RST 2'h0
`define BLLDL_PRE_RST 1'h1
`define BLLDL_LOW_EN_DEF 1'h1
`define BLLDL_ACT_DEF 1'h0
`endif

// ---- hdl/blldl_pkg.sv ----
// Types shared by the battery-low register block
package blldl_pkg;
    typedef logic [15:0] blldl_word_t;
    typedef logic [1:0] blldl_thr_t;
    typedef enum logic {BLLDL_ACT_INT_ONLY, BLLDL_ACT_INT_LATCH} blldl_act_t;
endpackage

// ---- hdl/blldl_reg.sv ----
// Battery low-voltage and discharge-limit configuration register
// Notes on behaviour
// (RULE_01) Bit 13 enables low-battery protection; default 1, restored by watchdog reset.
// (RULE_02) Bit 12 pre-charge to CC threshold; default 1 is 3V/cell; watchdog keeps it.
// (RULE_03) Bit 11 action: 0 interrupt only, 1 also latch off; watchdog restores 0. The code loads the synchronised otpAction strap instead.
// (RULE_04) Enabled and battery below threshold raises interrupt, optionally latches converter off.
// (RULE_05) Action selection only matters while the protection enable is 1.
// (RULE_06) Fault flag clears on charging or source-enable toggle; then source may restart.
// (RULE_07) Comparator result ignored while source mode is disabled.
// (RULE_08) Bits 10:9 threshold 3.0/3.1/3.2/3.3V per cell; default 00, watchdog keeps.
// (RULE_09) Bit 8 enables discharge current regulation; default 0, watchdog keeps.
// (RULE_10) Enable and action defaults come from one-time-programmable straps; reset loads fixed defaults, straps apply only on watchdog reset.
// (RULE_11) Bits 7:0 discharge limit, 50mA LSB, default 6.4A, watchdog keeps.
// (RULE_12) Bits 15:14 read zero; writes ignored.
`timescale 1ns/10ps
`include "blldl_defs.svh"
module blldl_reg (
    input wire logic sys_clk,                // 250 MHz device clock
    input wire logic reset,                  // Synchronous reset, high
    input wire logic watchdog_reset,         // Watchdog reset pulse, same clock
    input wire logic otpLowEn,               // OTP default for protection enable
    input wire logic otpAction,              // OTP default for action select
    input wire logic [7:0] regAddr,          // Register address from serial host
    input wire logic regWrite,               // Write strobe, one cycle
    input wire blldl_pkg::blldl_word_t regWdata, // Write data
    output blldl_pkg::blldl_word_t regRdata, // Read data, registered
    input wire logic sourceEnable,           // Source enable control bit
    input wire logic charging,               // Battery is being charged
    input wire logic low_batt_comparator,    // Async: battery below selected threshold
    output blldl_pkg::blldl_thr_t lowBattThreshold, // Threshold select to comparator
    output logic prechargeThreshold,         // Pre-charge to CC threshold select
    output logic discharge_current_reg_enable, // Discharge regulation enable
    output logic [7:0] discharge_current_limit, // Discharge limit, 50mA per LSB
    output logic lowBattInterrupt,           // Low-battery interrupt request, level
    output logic converterLatchOff,          // Converter latched off
    output logic discharge_fault_flag        // Discharge fault flag
);
    import blldl_pkg::*;

    logic lowEn;
    blldl_act_t low_batt_action_select;
    logic otpLowEnQ;
    logic otpActQ;
    logic cmpSync;
    logic srcPrev;
    logic [1:0] strapSync;

    // Straps and comparator arrive asynchronously
    blldl_sync #(.WIDTH(2)) u_strap_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .asyncIn({otpLowEn, otpAction}),
        .syncOut(strapSync)
    );
    blldl_sync #(.WIDTH(1)) u_cmp_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .asyncIn(low_batt_comparator),
        .syncOut(cmpSync)
    );

    // Decode of host access and fault conditions
    wire hit = (regAddr == `BLLDL_REG_OFFSET);
    wire wrHit = regWrite && hit;
    wire srcToggle = sourceEnable != srcPrev;
    wire faultClear = charging || srcToggle; // [RULE_06]
    wire lowDetect = lowEn && sourceEnable && cmpSync; // [RULE_04] [RULE_07]
    wire latchReq = lowDetect && (low_batt_action_select == BLLDL_ACT_INT_LATCH); // [RULE_05]
    wire blldl_word_t readWord = {2'h0, lowEn, prechargeThreshold, low_batt_action_select,
        lowBattThreshold, discharge_current_reg_enable, discharge_current_limit}; // [RULE_12]

    // Strap capture after reset release (the strapLoad pulse still loads the fixed defaults); keeps the synchronous reset branch free of port values
    logic strapLoad;
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            strapLoad <= 1'h1;
            otpLowEnQ <= `BLLDL_LOW_EN_DEF;
            otpActQ <= `BLLDL_ACT_DEF;
        end else begin
            strapLoad <= 1'h0;
            otpLowEnQ <= strapSync[1]; // [RULE_10]
            otpActQ <= strapSync[0]; // [RULE_10]
        end
    end

    // Watchdog-restored fields: protection enable and action
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lowEn <= `BLLDL_LOW_EN_DEF; // [RULE_01]
            low_batt_action_select <= blldl_act_t'(`BLLDL_ACT_DEF); // [RULE_03]
        end else if (watchdog_reset || strapLoad) begin
            lowEn <= otpLowEnQ; // [RULE_01] [RULE_10]
            low_batt_action_select <= blldl_act_t'(otpActQ); // [RULE_03] [RULE_10]
        end else if (wrHit) begin
            lowEn <= regWdata[`BLLDL_LOW_EN_BIT];
            low_batt_action_select <= blldl_act_t'(regWdata[`BLLDL_ACT_BIT]);
        end
    end

    // Fields that survive a watchdog reset
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prechargeThreshold <= `BLLDL_PRE_RST; // [RULE_02]
            lowBattThreshold <= `BLLDL_THR_RST; // [RULE_08]
            discharge_current_reg_enable <= `BLLDL_DSCHG_EN_RST; // [RULE_09]
            discharge_current_limit <= `BLLDL_LIMIT_RST; // [RULE_11]
        end else if (wrHit) begin
            prechargeThreshold <= regWdata[`BLLDL_PRE_BIT];
            lowBattThreshold <= regWdata[`BLLDL_THR_MSB:`BLLDL_THR_LSB]; // [RULE_08]
            discharge_current_reg_enable <= regWdata[`BLLDL_DSCHG_EN_BIT]; // [RULE_09]
            discharge_current_limit <= regWdata[`BLLDL_LIMIT_MSB:`BLLDL_LIMIT_LSB]; // [RULE_11]
        end
    end

    // Registered read data; unmapped address reads zero
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            regRdata <= 16'h0000;
        end else begin
            regRdata <= hit ? readWord : 16'h0000;
        end
    end

    // Fault and latch-off: detection wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            srcPrev <= 1'h0;
            lowBattInterrupt <= 1'h0;
            converterLatchOff <= 1'h0;
            discharge_fault_flag <= 1'h0;
        end else begin
            srcPrev <= sourceEnable;
            lowBattInterrupt <= lowDetect; // [RULE_04]
            if (lowDetect) begin
                discharge_fault_flag <= 1'h1; // [RULE_04]
            end else if (faultClear) begin
                discharge_fault_flag <= 1'h0; // [RULE_06]
            end
            if (latchReq) begin
                converterLatchOff <= 1'h1; // [RULE_04] [RULE_05]
            end else if (faultClear) begin
                converterLatchOff <= 1'h0; // [RULE_06]
            end
        end
    end
endmodule

// ---- hdl/blldl_sync.sv ----
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/10ps
module blldl_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,            // Device clock
    input wire logic reset,              // Synchronous reset, high
    input wire logic [WIDTH-1:0] asyncIn, // Raw level
    output logic [WIDTH-1:0] syncOut     // Synchronised level
);
    logic [WIDTH-1:0] stage1;

    // First stage only feeds the second
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// ---- testbench/blldl_host.sv ----
// Host model issuing register writes and reads
`timescale 1ns/10ps
module blldl_host (
    input wire logic sys_clk, // Clock
    input wire blldl_pkg::blldl_word_t regRdata, // Rdata
    output logic [7:0] regAddr, // Address
    output logic regWrite, // Strobe
    output blldl_pkg::blldl_word_t regWdata // Wdata
);
    import blldl_pkg::*;
    initial {regAddr, regWrite, regWdata} = {8'h0B, 1'h0, 16'h0000};
    // Data inverted after the strobe so stale values never pass
    task automatic wr(input logic [7:0] a, input blldl_word_t d);
        {regAddr, regWrite, regWdata} <= {a, 1'h1, d};
        @(posedge sys_clk);
        {regAddr, regWrite, regWdata} <= {8'h0B, 1'h0, ~d};
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, output blldl_word_t d);
        regAddr <= a;
        repeat (2) @(posedge sys_clk);
        d = regRdata;
    endtask
endmodule

// ---- testbench/blldl_reg_properties.sv ----
// Port-level checks for the battery-low register block
`timescale 1ns/10ps
module blldl_reg_check (
    input wire logic sys_clk, // Clock
    input wire logic reset, // Reset
    input wire logic watchdog_reset, // Watchdog
    input wire logic [7:0] regAddr, // Address
    input wire logic regWrite, // Strobe
    input wire blldl_pkg::blldl_word_t regWdata, // Wdata
    input wire blldl_pkg::blldl_word_t regRdata, // Rdata
    input wire logic sourceEnable, // Source on
    input wire logic low_batt_comparator, // Comparator
    input wire blldl_pkg::blldl_thr_t lowBattThreshold, // Threshold
    input wire logic prechargeThreshold, // Pre-charge
    input wire logic discharge_current_reg_enable, // Reg enable
    input wire logic [7:0] discharge_current_limit, // Limit
    input wire logic lowBattInterrupt, // Interrupt
    input wire logic converterLatchOff // Latch
);
    import blldl_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Watchdog-kept fields as one vector
    wire logic [11:0] flds = {prechargeThreshold, lowBattThreshold,
        discharge_current_reg_enable, discharge_current_limit};
    // Sync depth is two flops, so detection needs four settled cycles
    sequence s_low; (regAddr == 8'h0B && regRdata[13] && !regWrite && sourceEnable
        && low_batt_comparator) [*4]; endsequence
    property p_wr; regWrite && regAddr == 8'h0B && !watchdog_reset
        |=> flds == {$past(regWdata[12]), $past(regWdata[10:0])}; endproperty
    a_wr: assert property (p_wr) else $error("write fields");
    property p_rsv; regRdata[15:14] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
    property p_unmap; regAddr != 8'h0B |=> regRdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    property p_rd; regAddr == 8'h0B && !regWrite |=> regRdata[10:0] == flds[10:0]; endproperty
    a_rd: assert property (p_rd) else $error("readback");
    property p_wdog; watchdog_reset && !regWrite |=> $stable(flds); endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog kept");
    property p_nosrc; !sourceEnable [*4] |-> !lowBattInterrupt; endproperty
    a_nosrc: assert property (p_nosrc) else $error("no source");
    property p_irq; s_low |-> lowBattInterrupt; endproperty
    a_irq: assert property (p_irq) else $error("low interrupt");
    property p_act; $past(regAddr) == 8'h0B && !regRdata[11] |-> !$rose(converterLatchOff);
    endproperty
    a_act: assert property (p_act) else $error("latch action");
endmodule
bind blldl_reg blldl_reg_check i_chk (.*);

// ---- testbench/testbench.sv ----
// Self-checking bench for the battery-low register block
`timescale 1ns/10ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
    $display("[ERR] %s exp %h got %h", n, e, g); n_errors++; end end
module testbench;
    import blldl_pkg::*;
    logic sys_clk = 0, reset = 1, watchdog_reset = 0, sourceEnable = 0, charging = 0, cmp = 0;
    logic [7:0] regAddr, discharge_current_limit;
    logic regWrite, prechargeThreshold, discharge_current_reg_enable, irq, latchOff, flt;
    blldl_word_t regWdata, regRdata, rv;
    blldl_thr_t lowBattThreshold;
    int n_errors = 0, compares = 0, cycles = 0;
    always #2 sys_clk = ~sys_clk;
    blldl_reg i_blldl_reg (.sys_clk, .reset, .watchdog_reset, .otpLowEn(1'h1), .otpAction(1'h0),
        .regAddr, .regWrite, .regWdata, .regRdata, .sourceEnable, .charging,
        .low_batt_comparator(cmp), .lowBattThreshold, .prechargeThreshold,
        .discharge_current_reg_enable, .discharge_current_limit, .lowBattInterrupt(irq),
        .converterLatchOff(latchOff), .discharge_fault_flag(flt));
    blldl_host i_blldl_host (.sys_clk, .regRdata, .regAddr, .regWrite, .regWdata);
    task report_and_stop;
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard, far above the run's length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_errors++;
            report_and_stop();
        end
    end
    task automatic step(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Register tests, then low-battery behaviour
    initial begin
        step(5);
        reset <= 0;
        step(4);
        i_blldl_host.rd(8'h0B, rv);
        `CHK("dflt", 16'h3080, rv)
        i_blldl_host.wr(8'h0B, 16'hFFFF);
        i_blldl_host.rd(8'h0B, rv);
        `CHK("rsv", 16'h3FFF, rv)
        `CHK("lim", 8'hFF, discharge_current_limit)
        for (int i = 0; i < 4; i++) begin
            i_blldl_host.wr(8'h0B, {5'h04, i[1:0], 9'h000});
            `CHK("thr", i[1:0], lowBattThreshold)
        end
        i_blldl_host.wr(8'h0C, 16'h0000);
        i_blldl_host.rd(8'h0C, rv);
        `CHK("unmap", 16'h0000, rv)
        i_blldl_host.rd(8'h0B, rv);
        `CHK("kept", 16'h2600, rv)
        i_blldl_host.wr(8'h0B, 16'h0B55);
        watchdog_reset <= 1;
        step(1);
        watchdog_reset <= 0;
        i_blldl_host.rd(8'h0B, rv);
        `CHK("wdog", 16'h2355, rv)
        i_blldl_host.wr(8'h0B, 16'h2800);
        sourceEnable <= 1;
        cmp <= 1;
        step(6);
        `CHK("trip", 3'h7, {irq, latchOff, flt})
        cmp <= 0;
        step(4);
        `CHK("hold", 2'h1, {irq, latchOff})
        sourceEnable <= 0;
        step(1);
        sourceEnable <= 1;
        step(2);
        `CHK("togl", 2'h0, {latchOff, flt})
        i_blldl_host.wr(8'h0B, 16'h2000);
        cmp <= 1;
        step(6);
        `CHK("intonly", 2'h2, {irq, latchOff})
        cmp <= 0;
        step(4);
        charging <= 1;
        step(2);
        `CHK("chg", 1'h0, flt)
        sourceEnable <= 0;
        cmp <= 1;
        step(6);
        `CHK("nosrc", 1'h0, irq)
        report_and_stop();
    end
endmodule
